/* File: logic/hfr_regs.sv */
// Auto-calibration result and feedback control registers of the driver.
// Assumes the bus slave presents single-cycle read and write strobes on
// MCLK, and the calibration engine pulses its done flag on MCLK.
`timescale 1ns/1ps
module hfr_regs (
  input  wire logic              MCLK,         // System clock, 50 MHz
  input  wire logic              RESETN,       // Async reset, low
  input  wire logic [7:0]        REG_ADDR,     // Register offset
  input  wire logic              REG_WR,       // Write strobe, one cycle
  input  wire logic              REG_RD,       // Read strobe, one cycle
  input  wire logic [7:0]        REG_WDATA,    // Write data
  output logic [7:0]             REG_RDATA,    // Read data, next cycle
  input  wire hfr_pkg::hfr_cal_t CAL,          // Calibration result
  input  wire logic [7:0]        DRIVE_GAIN,   // Playback drive gain
  output logic [8:0]             SCALED_GAIN,  // Compensated drive gain
  output logic [15:0]            BEMF_MV,      // Rated back-EMF in mV
  output logic [7:0]             FB_GAIN,      // Driving feedback gain
  output logic [11:0]            BRAKE_GAIN,   // Braking feedback gain
  output logic                   LRA_MODE,     // Actuator is LRA
  output logic [1:0]             LOOP_GAIN     // Loop gain select
);
  import hfr_pkg::*;

  logic [7:0]  comp_reg;
  logic [7:0]  comp_next;
  logic [7:0]  bemf_reg;
  logic [7:0]  bemf_next;
  hfr_fbctl_t  fbctl_reg;
  hfr_fbctl_t  fbctl_next;
  logic [7:0]  rdata_next;

  // Address decode
  wire sel_comp  = (REG_ADDR == HFR_COMP_OFS);
  wire sel_bemf  = (REG_ADDR == HFR_BEMF_OFS);
  wire sel_fbctl = (REG_ADDR == HFR_FBCTL_OFS);
  wire wr_comp   = REG_WR && sel_comp;
  wire wr_bemf   = REG_WR && sel_bemf;
  wire wr_fbctl  = REG_WR && sel_fbctl;

  // Compensation from impedance; a zero reading saturates rather
  // than dividing by zero
  wire [15:0] comp_q    = (CAL.impedance == 8'h00) ? 16'hffff :
                          HFR_COMP_SCALE / {8'h00, CAL.impedance};
  wire [7:0]  comp_calc = (comp_q > 16'h00ff) ? 8'hff : comp_q[7:0];

  // Calibration wins a same-cycle collision with a host write, since
  // its result reflects the actuator actually fitted
  assign comp_next = CAL.done ? comp_calc :
                     wr_comp  ? REG_WDATA : comp_reg;
  assign bemf_next = CAL.done ? CAL.back_emf :
                     wr_bemf  ? REG_WDATA : bemf_reg;

  // Host sets type, ratio, loop gain and amp gain; calibration overrides amp gain
  always_comb begin
    fbctl_next = fbctl_reg;
    if (wr_fbctl) begin
      fbctl_next = hfr_fbctl_t'(REG_WDATA);
    end
    if (CAL.done) begin
      fbctl_next.back_emf_amp_gain = CAL.amp_gain;
    end
  end

  // Read mux; unmapped offsets read as zero
  assign rdata_next = sel_comp  ? comp_reg :
                      sel_bemf  ? bemf_reg :
                      sel_fbctl ? 8'(fbctl_reg) : 8'h00;

  // Register storage
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      comp_reg  <= HFR_COMP_RST;
      bemf_reg  <= HFR_BEMF_RST;
      fbctl_reg <= hfr_fbctl_t'(HFR_FBCTL_RST);
    end else begin
      comp_reg  <= comp_next;
      bemf_reg  <= bemf_next;
      fbctl_reg <= fbctl_next;
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_next;
    end
  end

  // Mode outputs straight from stored fields
  assign LRA_MODE  = fbctl_reg.actuator_type_select;
  assign LOOP_GAIN = fbctl_reg.loop_gain;

  // Gain arithmetic on the stored results
  hfr_gain_calc u_hfr_gain_calc (
    .MCLK       (MCLK),
    .RESETN     (RESETN),
    .DRIVE_GAIN (DRIVE_GAIN),
    .COMP       (comp_reg),
    .BEMF       (bemf_reg),
    .FBCTL      (fbctl_reg),
    .SCALED     (SCALED_GAIN),
    .BEMF_MV    (BEMF_MV),
    .FB_GAIN    (FB_GAIN),
    .BRAKE_GAIN (BRAKE_GAIN)
  );

  // Checks
  sequence s_cal_done;
    CAL.done;
  endsequence

  sequence s_host_comp;
    wr_comp && !CAL.done;
  endsequence

  AST_COMP_RESET: assert property (@(posedge MCLK)
    $rose(RESETN) |-> comp_reg == HFR_COMP_RST)
    else $error("compensation reset value wrong");

  AST_COMP_CAL: assert property (@(posedge MCLK) disable iff (!RESETN)
    s_cal_done |=> comp_reg == $past(comp_calc))
    else $error("compensation not derived from impedance");

  AST_SCALE: assert property (@(posedge MCLK) disable iff (!RESETN)
    $stable(comp_reg) && $stable(DRIVE_GAIN) |=>
    SCALED_GAIN == 9'((17'($past(DRIVE_GAIN)) *
      (17'd255 + 17'($past(comp_reg)))) / 17'd255))
    else $error("compensated drive gain wrong");

  AST_BEMF_RESET: assert property (@(posedge MCLK)
    $rose(RESETN) |-> bemf_reg == HFR_BEMF_RST)
    else $error("back-emf reset value wrong");

  AST_FB_MONO: assert property (@(posedge MCLK) disable iff (!RESETN)
    $stable(fbctl_reg) && bemf_reg == 8'h00 ##1 1'b1 |->
    FB_GAIN == 8'hff)
    else $error("feedback gain not saturated for zero back-emf");

  AST_BEMF_MV: assert property (@(posedge MCLK) disable iff (!RESETN)
    bemf_reg == 8'hff && !fbctl_reg.actuator_type_select &&
    fbctl_reg.back_emf_amp_gain == 2'd0 |=>
    BEMF_MV == 16'd4784)
    else $error("back-emf level conversion wrong");

  AST_TYPE: assert property (@(posedge MCLK) disable iff (!RESETN)
    wr_fbctl |=> LRA_MODE == $past(REG_WDATA[7]))
    else $error("actuator type not taken from bit 7");

  AST_RATIO: assert property (@(posedge MCLK) disable iff (!RESETN)
    fbctl_reg.brake_gain_ratio == 3'd2 ##1
    $stable(fbctl_reg) |-> BRAKE_GAIN == 12'(FB_GAIN) * 12'd3)
    else $error("brake ratio three times not applied");

  AST_AMP_CAL: assert property (@(posedge MCLK) disable iff (!RESETN)
    s_cal_done |=> fbctl_reg.back_emf_amp_gain == $past(CAL.amp_gain))
    else $error("calibration did not set amp gain");

  AST_HOST_WR: assert property (@(posedge MCLK) disable iff (!RESETN)
    s_host_comp ##1 REG_RD && sel_comp && !CAL.done |=>
    REG_RDATA == $past(REG_WDATA, 2))
    else $error("host write not read back");
endmodule

/* File: shared/hfr_pkg.sv */
// Package for the auto-calibration and feedback register slice.
// Assumes one clock domain and an internal register port behind the
// serial control bus slave.
package hfr_pkg;
  // Register offsets on the internal register port
  localparam logic [7:0] HFR_COMP_OFS   = 8'h18;
  localparam logic [7:0] HFR_BEMF_OFS   = 8'h19;
  localparam logic [7:0] HFR_FBCTL_OFS  = 8'h1a;
  // Values after reset
  localparam logic [7:0] HFR_COMP_RST   = 8'h0c;
  localparam logic [7:0] HFR_BEMF_RST   = 8'h6f;
  localparam logic [7:0] HFR_FBCTL_RST  = 8'h36;
  // Feedback control field positions
  localparam int HFR_TYPE_BIT   = 7;
  localparam int HFR_BRAKE_LSB  = 4;
  localparam int HFR_LOOP_LSB   = 2;
  localparam int HFR_AMP_LSB    = 0;
  // Full-scale code and back-EMF reference in millivolts
  localparam logic [8:0]  HFR_FULL_CODE = 9'h0ff;
  localparam logic [31:0] HFR_BEMF_REF_MV = 32'h000004c4; // 1220 mV
  // Numerator turning measured impedance into a compensation code
  localparam logic [15:0] HFR_COMP_SCALE = 16'h0bf4;
  // Numerator turning back-EMF level (mV) into feedback gain
  localparam logic [19:0] HFR_FB_SCALE   = 20'h3e800;
  // Back-EMF amplifier gain per code in thousandths, ERM then LRA
  localparam logic [11:0] HFR_AMP_ERM0 = 12'h0ff;  // 0.255x
  localparam logic [11:0] HFR_AMP_ERM1 = 12'h314;  // 0.788x
  localparam logic [11:0] HFR_AMP_ERM2 = 12'h3e8;
  localparam logic [11:0] HFR_AMP_ERM3 = 12'h7d0;
  localparam logic [11:0] HFR_AMP_LRA0 = 12'h3e8;
  localparam logic [11:0] HFR_AMP_LRA1 = 12'h7d0;
  localparam logic [11:0] HFR_AMP_LRA2 = 12'hbb8;
  localparam logic [11:0] HFR_AMP_LRA3 = 12'hfa0;

  typedef enum {HFR_ERM, HFR_LRA} hfr_actuator_t;

  // Feedback control register layout
  typedef struct packed {
    logic       actuator_type_select;
    logic [2:0] brake_gain_ratio;
    logic [1:0] loop_gain;
    logic [1:0] back_emf_amp_gain;
  } hfr_fbctl_t;

  // Result of one calibration run
  typedef struct packed {
    logic       done;
    logic [7:0] impedance;
    logic [7:0] back_emf;
    logic [1:0] amp_gain;
  } hfr_cal_t;
endpackage

/* File: logic/hfr_gain_calc.sv */
// Gain arithmetic for playback and closed-loop drive.
// Assumes its inputs are register values on the same clock.
`timescale 1ns/1ps
module hfr_gain_calc (
  input  wire logic              MCLK,       // System clock
  input  wire logic              RESETN,     // Async reset, low
  input  wire logic [7:0]        DRIVE_GAIN, // Raw drive gain
  input  wire logic [7:0]        COMP,       // Compensation code
  input  wire logic [7:0]        BEMF,       // Rated back-EMF code
  input  wire hfr_pkg::hfr_fbctl_t FBCTL,    // Feedback control fields
  output logic [8:0]             SCALED,     // Compensated drive gain
  output logic [15:0]            BEMF_MV,    // Back-EMF level in mV
  output logic [7:0]             FB_GAIN,    // Driving feedback gain
  output logic [11:0]            BRAKE_GAIN  // Braking feedback gain
);
  import hfr_pkg::*;

  // Drive gain times (1 + comp/255)
  wire [16:0] prod_w   = DRIVE_GAIN * (HFR_FULL_CODE + {1'b0, COMP});
  wire [8:0]  scaled_w = 9'(prod_w / 17'(HFR_FULL_CODE));

  // Amplifier gain in thousandths depends on actuator type
  wire [11:0] amp_erm = (FBCTL.back_emf_amp_gain == 2'd0) ? HFR_AMP_ERM0 :
                        (FBCTL.back_emf_amp_gain == 2'd1) ? HFR_AMP_ERM1 :
                        (FBCTL.back_emf_amp_gain == 2'd2) ? HFR_AMP_ERM2 :
                        HFR_AMP_ERM3;
  wire [11:0] amp_lra = (FBCTL.back_emf_amp_gain == 2'd0) ? HFR_AMP_LRA0 :
                        (FBCTL.back_emf_amp_gain == 2'd1) ? HFR_AMP_LRA1 :
                        (FBCTL.back_emf_amp_gain == 2'd2) ? HFR_AMP_LRA2 :
                        HFR_AMP_LRA3;
  wire [11:0] amp_w   = FBCTL.actuator_type_select ? amp_lra : amp_erm;

  // Level = code/255 * 1.22 V / amp gain
  wire [31:0] num_w   = {24'h0, BEMF} * HFR_BEMF_REF_MV * 32'd1000;
  wire [31:0] den_w   = 32'(amp_w) * 32'(HFR_FULL_CODE);
  wire [15:0] mv_w    = 16'(num_w / den_w);

  // Weaker back-EMF needs more loop gain, so gain is inverse
  wire [19:0] fbq_w   = (mv_w == 16'h0) ? 20'hfffff :
                        HFR_FB_SCALE / 20'(mv_w);
  wire [7:0]  fb_w    = (fbq_w > 20'h000ff) ? 8'hff : fbq_w[7:0];

  // Brake to drive ratio; code 7 turns braking off
  wire [4:0]  mult_w  = (FBCTL.brake_gain_ratio == 3'd0) ? 5'd1 :
                        (FBCTL.brake_gain_ratio == 3'd1) ? 5'd2 :
                        (FBCTL.brake_gain_ratio == 3'd2) ? 5'd3 :
                        (FBCTL.brake_gain_ratio == 3'd3) ? 5'd4 :
                        (FBCTL.brake_gain_ratio == 3'd4) ? 5'd6 :
                        (FBCTL.brake_gain_ratio == 3'd5) ? 5'd8 :
                        (FBCTL.brake_gain_ratio == 3'd6) ? 5'd16 : 5'd0;
  wire [11:0] brake_w = 12'(fb_w * mult_w);

  // Outputs registered so downstream drive logic sees stable values
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      SCALED     <= 9'h000;
      BEMF_MV    <= 16'h0000;
      FB_GAIN    <= 8'h00;
      BRAKE_GAIN <= 12'h000;
    end else begin
      SCALED     <= scaled_w;
      BEMF_MV    <= mv_w;
      FB_GAIN    <= fb_w;
      BRAKE_GAIN <= brake_w;
    end
  end
endmodule

/* File: sim/hfr_regs_bench.sv */
// Self-checking bench for the calibration result and feedback registers.
// Assumes the register port and calibration input of hfr_regs as handed
// over: single-cycle strobes on MCLK, read data one cycle after the strobe.
`timescale 1ns/1ps
module hfr_regs_bench;
  import hfr_pkg::*;

  typedef struct {
    string       what;
    logic [15:0] exp;
  } hfr_note_t;

  logic        mclk;
  logic        resetn;
  logic        reg_wr;
  logic        reg_rd;
  logic        probe;
  logic        rd_seen;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  drive_gain;
  logic [7:0]  fb_gain;
  logic [8:0]  scaled_gain;
  logic [15:0] bemf_mv;
  logic [11:0] brake_gain;
  logic        lra_mode;
  logic [1:0]  loop_gain;
  logic [15:0] lfsr_reg;
  hfr_cal_t    cal;
  hfr_note_t   notes[$];
  int          n_fail;
  int          n_checks;
  int          exp_mv;
  int          exp_fb;
  // Brake to drive multiplier per ratio code; code 7 disables braking
  int          brake_mult[8] = '{1, 2, 3, 4, 6, 8, 16, 0};

  hfr_regs u_hfr_regs (
    .MCLK        (mclk),
    .RESETN      (resetn),
    .REG_ADDR    (reg_addr),
    .REG_WR      (reg_wr),
    .REG_RD      (reg_rd),
    .REG_WDATA   (reg_wdata),
    .REG_RDATA   (reg_rdata),
    .CAL         (cal),
    .DRIVE_GAIN  (drive_gain),
    .SCALED_GAIN (scaled_gain),
    .BEMF_MV     (bemf_mv),
    .FB_GAIN     (fb_gain),
    .BRAKE_GAIN  (brake_gain),
    .LRA_MODE    (lra_mode),
    .LOOP_GAIN   (loop_gain)
  );

  // Free-running 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Pseudo-random source, fixed start so every run is the same
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Picks the output named by a note; unknown names never match
  function automatic logic [15:0] pick(string w);
    case (w)
      "scaled":  return {7'h00, scaled_gain};
      "bemf_mv": return bemf_mv;
      "fb_gain": return {8'h00, fb_gain};
      "brake":   return {4'h0, brake_gain};
      "lra":     return {15'h0000, lra_mode};
      "loop":    return {14'h0000, loop_gain};
      default:   return 16'hxxxx;
    endcase
  endfunction

  task automatic check(logic [15:0] seen);
    hfr_note_t n;
    if (notes.size() == 0) begin
      n_fail++;
      $display("Error result with no expectation, seen %h", seen);
    end else begin
      n = notes.pop_front();
      n_checks++;
      if (seen !== n.exp) begin
        n_fail++;
        $display("Error %s expected %h seen %h", n.what, n.exp, seen);
      end
    end
  endtask

  // Read data is due one cycle after the strobe edge
  always @(posedge mclk) rd_seen <= reg_rd;

  // Watcher: looks just after the falling edge, once outputs have settled
  always @(negedge mclk) begin
    #1;
    if (rd_seen === 1'b1) check({8'h00, reg_rdata});
    if (probe === 1'b1) check(pick(notes[0].what));
  end

  // Each driver task leaves one idle edge so no strobe is set twice at once
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    notes.push_back('{what: "rdata", exp: e});
    @(negedge mclk);
    reg_rd = 1'b0;
  endtask

  // Write, then read the same offset back at the very next edge
  task automatic wr_rd(logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    notes.push_back('{what: "rdata", exp: {8'h00, d}});
    @(negedge mclk);
    reg_rd = 1'b0;
  endtask

  task automatic look(string w, logic [15:0] e);
    @(negedge mclk);
    notes.push_back('{what: w, exp: e});
    probe = 1'b1;
    @(negedge mclk);
    probe = 1'b0;
  endtask

  task automatic calib(logic [7:0] imp, logic [7:0] bemf, logic [1:0] amp);
    @(negedge mclk);
    cal = '{done: 1'b1, impedance: imp, back_emf: bemf, amp_gain: amp};
    @(negedge mclk);
    cal.done = 1'b0;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    summarize;
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    probe = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    drive_gain = 8'h00;
    cal = '0;
    lfsr_reg = 16'h0010;
    n_fail = 0;
    n_checks = 0;
    repeat (16) @(posedge mclk);
    @(negedge mclk) resetn = 1'b1;
    rd(HFR_COMP_OFS, 16'h000c);
    rd(HFR_BEMF_OFS, 16'h006f);
    rd(HFR_FBCTL_OFS, 16'h0036);
    look("lra", 16'h0000);
    $display("test reset values done");
    // Random results written by the host must read back and drive playback
    for (int i = 0; i < 4; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      wr_rd(HFR_COMP_OFS, lfsr_reg[7:0]);
      wr_rd(HFR_BEMF_OFS, lfsr_reg[15:8]);
      drive_gain = lfsr_reg[15:8];
      exp_mv = int'(drive_gain) * (255 + int'(lfsr_reg[7:0])) / 255;
      look("scaled", exp_mv[15:0]);
    end
    wr(8'h1b, 8'hff);
    rd(8'h1b, 16'h0000);
    $display("test host access done");
    // Type and brake ratio are set up before calibrating, as advised
    wr(HFR_FBCTL_OFS, 8'h34);
    // Calibration runs with ERM amplifier codes 0 and 1 of the four
    for (int a = 0; a < 2; a++) begin
      calib(8'h80, 8'hff, a[1:0]);
      rd(HFR_COMP_OFS, 16'h0017);
      rd(HFR_BEMF_OFS, 16'h00ff);
      rd(HFR_FBCTL_OFS, {8'h00, 6'h0d, a[1:0]});
      exp_mv = 255 * int'(HFR_BEMF_REF_MV) * 1000 / (int'(HFR_FULL_CODE) *
               int'(a == 1 ? HFR_AMP_ERM1 : HFR_AMP_ERM0));
      look("bemf_mv", exp_mv[15:0]);
      exp_fb = int'(HFR_FB_SCALE) / exp_mv;
      if (exp_fb > 255) exp_fb = 255;
      look("fb_gain", exp_fb[15:0]);
    end
    $display("test calibration done");
    // Every brake ratio code with the amplifier code kept at 1
    for (int c = 0; c < 8; c++) begin
      wr(HFR_FBCTL_OFS, {1'b0, c[2:0], 4'h5});
      exp_mv = exp_fb * brake_mult[c];
      look("brake", exp_mv[15:0]);
    end
    wr(HFR_FBCTL_OFS, 8'hb9);
    look("lra", 16'h0001);
    look("loop", 16'h0002);
    exp_mv = 255 * int'(HFR_BEMF_REF_MV) * 1000 /
             (int'(HFR_FULL_CODE) * int'(HFR_AMP_LRA1));
    look("bemf_mv", exp_mv[15:0]);
    rd(HFR_FBCTL_OFS, 16'h00b9);
    $display("test feedback control done");
    summarize;
  end
endmodule
